// ==== logic/hcp_pkg.sv ====
`default_nettype none
package hcp_pkg;
  // ----------------------------------------
  // Register map and stream
  // ----------------------------------------
  localparam logic [7:0] STREAM_REG = 8'hFF;
  localparam logic [7:0] FILLER_BYTE = 8'hFF;
  localparam logic [7:0] OTHER_REG_VALUE = 8'h00;
  localparam int BUF_AW = 4;
  localparam logic [4:0] BUF_FULL = 5'h10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] UART_STOP_BIT = 4'h9;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // ----------------------------------------
  // Synchroniser lanes
  // ----------------------------------------
  localparam int SY_W = 7;
  localparam int SY_P18 = 0;
  localparam int SY_P19 = 1;
  localparam int SY_P21 = 2;
  localparam int SY_RSTN = 3;
  localparam int SY_WAKE = 4;
  localparam int SY_SEL = 5;
  localparam int SY_VBUS = 6;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_AACK = 3'b010, I_WR = 3'b011,
    I_WACK = 3'b100, I_RD = 3'b101, I_RACK = 3'b110
  } hcp_i2c_st_t;
  typedef struct packed {
    logic enable;
    logic active_high;
    logic on_txd;
    logic [7:0] threshold;
    logic [15:0] baud_div;
  } hcp_port_cfg_t;
  localparam hcp_port_cfg_t PORT_CFG_RST = '{1'b0, 1'b1, 1'b0, 8'h01, 16'h0363};
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } hcp_byte_t;
endpackage : hcp_pkg
`default_nettype wire

// ==== logic/hcp_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE_01 - The UART runs asynchronous receive and transmit only, at a configurable bit rate, with no handshake lines.
// RULE_02 - The USB port announces a full-speed 12 Mb/s device by enabling its pull-up on the plus line.
// RULE_03 - The I2C channel is a slave only and never starts a transfer.
// RULE_04 - The I2C channel follows Fast-mode start, stop, acknowledge and bit timing driven by the host.
// RULE_05 - The register address counter advances by one per byte read and sticks at 0xFF, which streams buffer bytes.
// RULE_06 - The host reads the 0xFF stream continuously without re-addressing before each byte.
// RULE_07 - SPI is off by default, only works with the select strap low, and never runs alongside UART or I2C.
// RULE_08 - The four shared pins carry I2C data, I2C clock, UART out, UART in, or SPI select, clock, MISO, MOSI; the SPI slave ignores MOSI on pin 21.
// RULE_09 - The active-low reset pin is input only and puts the receiver into hardware reset.
// RULE_10 - The wake input serves as a wake-up interrupt and aiding input and may float when unused.
// RULE_11 - The data-pending signal is active while output data waits for the host.
// RULE_12 - Data-pending has configurable polarity and goes active once the byte count reaches a threshold.
// RULE_13 - Data-pending is disabled after reset and can replace the UART output pin when enabled.
// RULE_14 - Data-pending returns inactive once the byte count falls below the threshold.
// RULE_15 - Reading the stream with nothing pending returns a fixed filler byte.
module hcp_top #(
  parameter logic [6:0] SLAVE_ADDR = hcp_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin18_in,
  output logic pin18_out,
  output logic pin18_oe_n,
  input wire logic pin19_in,
  output logic pin20_out,
  input wire logic pin21_in,
  input wire logic reset_n_pin,
  input wire logic external_wake_input,
  input wire logic iface_sel_pin,
  input wire logic vbus_present,
  output logic full_speed_plus_pullup,
  output logic sys_reset_req,
  output logic wake_level,
  output logic wake_pulse,
  output logic spi_mode,
  output logic data_pending,
  input wire logic cfg_load,
  input wire hcp_pkg::hcp_port_cfg_t cfg_in,
  input wire hcp_pkg::hcp_byte_t msg_in,
  output logic msg_ready,
  input wire hcp_pkg::hcp_byte_t utx_in,
  output logic utx_ready,
  output hcp_pkg::hcp_byte_t urx_out
);
  import hcp_pkg::*;

  // ----------------------------------------
  // Synchronisers, strap, misc pins
  // ----------------------------------------
  logic [SY_W-1:0] sy1, sy2, syp;
  logic [1:0] settle;
  logic strap_done;
  hcp_port_cfg_t cfg;
  always_ff @(posedge clk) begin
    sy1 <= {vbus_present, iface_sel_pin, external_wake_input, reset_n_pin, pin21_in, pin19_in, pin18_in};
    sy2 <= sy1;
    syp <= sy2;
    if (rst) begin
      settle <= 2'h0;
      strap_done <= 1'b0;
      spi_mode <= 1'b0;
      cfg <= PORT_CFG_RST; // RULE_13
      sys_reset_req <= 1'b0;
      wake_level <= 1'b0;
      wake_pulse <= 1'b0;
      full_speed_plus_pullup <= 1'b0;
      pin18_out <= 1'b0;
    end else begin
      if (!strap_done) begin
        settle <= settle + 2'h1;
        // Strap caught after the sync chain has filled
        if (settle == STRAP_SETTLE) begin
          strap_done <= 1'b1;
          spi_mode <= ~sy2[SY_SEL]; // RULE_07
        end
      end
      if (cfg_load) cfg <= cfg_in;
      sys_reset_req <= ~sy2[SY_RSTN]; // RULE_09
      wake_level <= sy2[SY_WAKE]; // RULE_10
      wake_pulse <= sy2[SY_WAKE] & ~syp[SY_WAKE]; // RULE_10
      full_speed_plus_pullup <= sy2[SY_VBUS]; // RULE_02
      pin18_out <= 1'b0;
    end
  end

  logic i2c_on, spi_on, uart_on;
  assign i2c_on = strap_done & ~spi_mode; // RULE_07
  assign spi_on = strap_done & spi_mode;
  assign uart_on = i2c_on;
  logic scl_rise, scl_fall, sda, i2c_start, i2c_stop, cs_fall, cs_n;
  assign sda = sy2[SY_P18];
  assign cs_n = sy2[SY_P18];
  assign scl_rise = sy2[SY_P19] & ~syp[SY_P19];
  assign scl_fall = ~sy2[SY_P19] & syp[SY_P19];
  assign i2c_start = sy2[SY_P19] & syp[SY_P19] & syp[SY_P18] & ~sda; // RULE_04
  assign i2c_stop = sy2[SY_P19] & syp[SY_P19] & ~syp[SY_P18] & sda; // RULE_04
  assign cs_fall = syp[SY_P18] & ~cs_n;

  // ----------------------------------------
  // Message buffer, I2C slave, SPI slave
  // ----------------------------------------
  logic [7:0] mem [0:(1<<BUF_AW)-1];
  logic [BUF_AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [4:0] count, next_count;
  hcp_i2c_st_t ist, next_ist;
  logic [3:0] bcnt, next_bcnt, sbcnt, next_sbcnt;
  logic [7:0] sh, next_sh, ssh, next_ssh, reg_addr, next_addr;
  logic rw, next_rw, first_wr, next_first, rack_ok, next_rack;
  logic from_buf, next_from, sfrom, next_sfrom, miso, next_miso;
  logic next_sda_oe_n, next_msg_ready, push, pop;
  logic [7:0] buf_byte, rd_byte;
  logic rd_real;
  assign buf_byte = (count != 5'h00) ? mem[rptr] : FILLER_BYTE; // RULE_15
  assign rd_byte = (reg_addr == STREAM_REG) ? buf_byte : OTHER_REG_VALUE;
  assign rd_real = (reg_addr == STREAM_REG) && (count != 5'h00);

  always_comb begin
    next_ist = ist;
    next_bcnt = bcnt;
    next_sh = sh;
    next_rw = rw;
    next_first = first_wr;
    next_addr = reg_addr;
    next_rack = rack_ok;
    next_from = from_buf;
    next_sda_oe_n = pin18_oe_n;
    next_ssh = ssh;
    next_sbcnt = sbcnt;
    next_sfrom = sfrom;
    next_miso = miso;
    pop = 1'b0;
    push = msg_in.valid & msg_ready;
    // Slave only: the data line is released unless answering the host
    if (!i2c_on || i2c_stop) begin // RULE_03
      next_ist = I_IDLE;
      next_sda_oe_n = 1'b1;
    end else if (i2c_start) begin
      next_ist = I_ADDR;
      next_bcnt = 4'h0;
      next_sda_oe_n = 1'b1;
    end else begin
      case (ist)
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            next_sh = {sh[6:0], sda};
            next_bcnt = bcnt + 4'h1;
          end else if (scl_fall && bcnt == BITS_PER_BYTE) begin
            next_bcnt = 4'h0;
            if (ist == I_ADDR) begin
              if (sh[7:1] == SLAVE_ADDR) begin
                next_ist = I_AACK;
                next_sda_oe_n = 1'b0;
                next_rw = sh[0];
                next_first = 1'b1;
              end else begin
                next_ist = I_IDLE;
              end
            end else begin
              next_ist = I_WACK;
              next_sda_oe_n = 1'b0;
              next_first = 1'b0;
              if (first_wr) next_addr = sh;
            end
          end
        end
        I_AACK, I_WACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_ist = I_RD;
              next_sh = rd_byte;
              next_from = rd_real;
              next_sda_oe_n = rd_byte[7];
              next_bcnt = 4'h1;
            end else begin
              next_ist = I_WR;
              next_sda_oe_n = 1'b1;
            end
          end
        end
        I_RD: begin
          if (scl_fall) begin
            if (bcnt == BITS_PER_BYTE) begin
              next_ist = I_RACK;
              next_sda_oe_n = 1'b1;
              // Pointer moves once per byte, so re-addressing mid-stream is never needed
              if (reg_addr == STREAM_REG) pop = from_buf; // RULE_05 RULE_06
              else next_addr = reg_addr + 8'h01; // RULE_05
            end else begin
              next_sh = {sh[6:0], 1'b0};
              next_sda_oe_n = sh[6];
              next_bcnt = bcnt + 4'h1;
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            next_rack = ~sda; // RULE_04
          end else if (scl_fall) begin
            if (rack_ok) begin
              next_ist = I_RD;
              next_sh = rd_byte;
              next_from = rd_real;
              next_sda_oe_n = rd_byte[7];
              next_bcnt = 4'h1;
            end else begin
              next_ist = I_IDLE;
            end
          end
        end
        default: next_ist = I_IDLE;
      endcase
    end
    // SPI mode 0 read stream
    if (!spi_on || cs_n) begin
      next_sbcnt = 4'h0;
    end else if (cs_fall || (scl_fall && sbcnt == BITS_PER_BYTE)) begin
      next_ssh = buf_byte;
      next_sfrom = count != 5'h00;
      next_miso = buf_byte[7];
      next_sbcnt = 4'h0;
    end else if (scl_rise) begin
      next_sbcnt = sbcnt + 4'h1;
      if (sbcnt == BITS_PER_BYTE - 4'h1) pop = sfrom;
    end else if (scl_fall) begin
      next_ssh = {ssh[6:0], 1'b0};
      next_miso = ssh[6];
    end
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
    next_count = count + {4'h0, push} - {4'h0, pop};
    next_msg_ready = next_count != BUF_FULL;
  end

  always_ff @(posedge clk) begin
    if (push) mem[wptr] <= msg_in.data;
    if (rst) begin
      ist <= I_IDLE;
      bcnt <= 4'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      first_wr <= 1'b0;
      reg_addr <= 8'h00;
      rack_ok <= 1'b0;
      from_buf <= 1'b0;
      pin18_oe_n <= 1'b1;
      ssh <= 8'h00;
      sbcnt <= 4'h0;
      sfrom <= 1'b0;
      miso <= 1'b0;
      wptr <= '0;
      rptr <= '0;
      count <= 5'h00;
      msg_ready <= 1'b0;
    end else begin
      ist <= next_ist;
      bcnt <= next_bcnt;
      sh <= next_sh;
      rw <= next_rw;
      first_wr <= next_first;
      reg_addr <= next_addr;
      rack_ok <= next_rack;
      from_buf <= next_from;
      pin18_oe_n <= next_sda_oe_n;
      ssh <= next_ssh;
      sbcnt <= next_sbcnt;
      sfrom <= next_sfrom;
      miso <= next_miso;
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      msg_ready <= next_msg_ready;
    end
  end

  // ----------------------------------------
  // UART, data-pending, shared output pin
  // ----------------------------------------
  logic tx_busy, next_tx_busy, rx_busy, next_rx_busy, pend_lvl, next_pin20, next_utx_ready;
  logic [3:0] tx_bits, next_tx_bits, rx_bits, next_rx_bits;
  logic [15:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
  logic [9:0] tx_sh, next_tx_sh;
  logic [7:0] rx_sh, next_rx_sh;
  hcp_byte_t next_urx;
  logic rxd;
  assign rxd = sy2[SY_P21];
  // Level, not pulse: a host may wait on it instead of polling
  assign pend_lvl = (cfg.enable && {3'h0, count} >= cfg.threshold) ~^ cfg.active_high; // RULE_11 RULE_12 RULE_14

  always_comb begin
    next_tx_busy = tx_busy;
    next_tx_bits = tx_bits;
    next_tx_cnt = tx_cnt;
    next_tx_sh = tx_sh;
    next_rx_busy = rx_busy;
    next_rx_bits = rx_bits;
    next_rx_cnt = rx_cnt;
    next_rx_sh = rx_sh;
    next_urx = '{1'b0, urx_out.data};
    if (utx_in.valid && utx_ready) begin // RULE_01
      next_tx_busy = 1'b1;
      next_tx_sh = {1'b1, utx_in.data, 1'b0};
      next_tx_bits = 4'h0;
      next_tx_cnt = cfg.baud_div;
    end else if (tx_busy && tx_cnt == 16'h0000) begin
      next_tx_cnt = cfg.baud_div;
      next_tx_sh = {1'b1, tx_sh[9:1]};
      next_tx_bits = tx_bits + 4'h1;
      if (tx_bits == UART_STOP_BIT) next_tx_busy = 1'b0;
    end else if (tx_busy) begin
      next_tx_cnt = tx_cnt - 16'h0001;
    end
    // Start edge found, then sample mid-bit; a short glitch aborts
    if (!uart_on) begin
      next_rx_busy = 1'b0;
    end else if (!rx_busy && !rxd && syp[SY_P21]) begin // RULE_01
      next_rx_busy = 1'b1;
      next_rx_bits = 4'h0;
      next_rx_cnt = {1'b0, cfg.baud_div[15:1]};
    end else if (rx_busy && rx_cnt == 16'h0000) begin
      next_rx_cnt = cfg.baud_div;
      next_rx_bits = rx_bits + 4'h1;
      if (rx_bits == 4'h0 && rxd) begin
        next_rx_busy = 1'b0;
      end else if (rx_bits == UART_STOP_BIT) begin
        next_rx_busy = 1'b0;
        next_urx = '{rxd, rx_sh};
      end else if (rx_bits != 4'h0) begin
        next_rx_sh = {rxd, rx_sh[7:1]};
      end
    end else if (rx_busy) begin
      next_rx_cnt = rx_cnt - 16'h0001;
    end
    next_utx_ready = uart_on & ~next_tx_busy;
    if (spi_on) next_pin20 = miso; // RULE_08
    else if (cfg.enable && cfg.on_txd) next_pin20 = pend_lvl; // RULE_13
    else next_pin20 = tx_busy ? tx_sh[0] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_busy <= 1'b0;
      tx_bits <= 4'h0;
      tx_cnt <= 16'h0000;
      tx_sh <= 10'h3FF;
      rx_busy <= 1'b0;
      rx_bits <= 4'h0;
      rx_cnt <= 16'h0000;
      rx_sh <= 8'h00;
      urx_out <= '0;
      utx_ready <= 1'b0;
      pin20_out <= 1'b1;
      data_pending <= 1'b0;
    end else begin
      tx_busy <= next_tx_busy;
      tx_bits <= next_tx_bits;
      tx_cnt <= next_tx_cnt;
      tx_sh <= next_tx_sh;
      rx_busy <= next_rx_busy;
      rx_bits <= next_rx_bits;
      rx_cnt <= next_rx_cnt;
      rx_sh <= next_rx_sh;
      urx_out <= next_urx;
      utx_ready <= next_utx_ready;
      pin20_out <= next_pin20;
      data_pending <= pend_lvl; // RULE_11
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_done;
    i2c_on && !i2c_stop && !i2c_start && ist == I_RD && scl_fall && bcnt == BITS_PER_BYTE;
  endsequence
  sequence s_tx_load;
    utx_in.valid && utx_ready && !spi_on && !(cfg.enable && cfg.on_txd);
  endsequence
  a_addr_saturate: assert property (s_rd_done and reg_addr == STREAM_REG |=> reg_addr == STREAM_REG) // RULE_05
    else $error("stream address left 0xFF");
  a_addr_advance: assert property (s_rd_done and reg_addr != STREAM_REG |=> reg_addr == $past(reg_addr) + 8'h01) // RULE_05
    else $error("address did not advance by one");
  a_slave_only: assert property (!pin18_oe_n |-> (ist == I_AACK || ist == I_WACK || ist == I_RD)) // RULE_03
    else $error("data line driven outside slave reply");
  a_spi_exclusive: assert property (spi_on |-> ##1 (pin18_oe_n && !utx_ready && !rx_busy)) // RULE_07
    else $error("UART or I2C active in SPI mode");
  a_pin_map: assert property (spi_on && $stable(spi_on) |=> pin20_out == $past(miso)) // RULE_08
    else $error("MISO not on shared pin");
  a_pend_level: assert property (cfg.enable && {3'h0, count} >= cfg.threshold |=> data_pending == $past(cfg.active_high)) // RULE_12
    else $error("pending not active at threshold");
  a_pend_drop: assert property ($fell({3'h0, count} >= cfg.threshold) |-> ##1 data_pending == !$past(cfg.active_high)) // RULE_14
    else $error("pending stayed active below threshold");
  a_pend_reset: assert property ($fell(rst) |-> !cfg.enable) // RULE_13
    else $error("pending enabled after reset");
  a_filler_byte: assert property (i2c_on && ((ist == I_AACK && rw) || (ist == I_RACK && rack_ok)) && scl_fall // RULE_15
    && !i2c_stop && !i2c_start && reg_addr == STREAM_REG && count == 5'h00 |=> sh == FILLER_BYTE && !from_buf)
    else $error("empty stream did not give filler");
  a_uart_start: assert property (s_tx_load |-> ##1 tx_busy ##1 !pin20_out [*2]) // RULE_01
    else $error("UART start bit missing");
  a_reset_follow: assert property (!sy2[SY_RSTN] |=> sys_reset_req) // RULE_09
    else $error("reset pin not followed");
endmodule : hcp_top
`default_nettype wire

// ==== tb/hcp_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Host master on the two-wire channel
// ----------------------------------------
module hcp_host_model (
  input wire logic sda,
  output logic scl,
  output logic sda_drv,
  output logic rd_evt,
  output logic [7:0] rd_data
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_evt = 1'b0;
    rd_data = 8'h00;
  end
  // Data moves only while the clock is low, 80 ns per bit
  task automatic bitx(input logic b, output logic r);
    #10 sda_drv = b;
    #30 scl = 1'b1;
    #30 r = sda;
    #10 scl = 1'b0;
  endtask : bitx
  task automatic start_cond();
    sda_drv = 1'b1;
    scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    #10 sda_drv = 1'b0;
    #30 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
  endtask : stop_cond
  task automatic wr_byte(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, ack_n);
  endtask : wr_byte
  // Stream is read back to back, never re-addressed per byte
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
    bitx(last, r);
    rd_data = b;
    rd_evt = 1'b1;
    #1 rd_evt = 1'b0;
  endtask : rd_byte
endmodule : hcp_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hcp_pkg::*;
  logic clk = 1'b0;
  logic rst, reset_n_pin, external_wake_input, iface_sel_pin, vbus_present, cfg_load, loop_en, spi_cs_n, spi_sck;
  hcp_port_cfg_t cfg_in;
  hcp_byte_t msg_in, utx_in, urx_out;
  logic pin18_out, pin18_oe_n, pin20_out, full_speed_plus_pullup, sys_reset_req, wake_level, wake_pulse;
  logic spi_mode, data_pending, msg_ready, utx_ready, scl, sda_drv, rd_evt, ack_n;
  logic [7:0] rd_data, got;
  logic [7:0] byte_q[$];
  logic [7:0] vals[3];
  int miscompares = 0;
  int total_checks = 0;
  int n;
  // Open-drain line with pull-up: anyone pulling low wins
  wire logic sda = sda_drv & (pin18_oe_n | pin18_out);
  wire logic pin18_in = iface_sel_pin ? sda : spi_cs_n;
  wire logic pin19_in = iface_sel_pin ? scl : spi_sck;
  wire logic pin21_in = loop_en ? pin20_out : 1'b1;

  always #5 clk = ~clk;

  hcp_top hcp_top_inst (.clk(clk), .rst(rst), .pin18_in(pin18_in), .pin18_out(pin18_out), .pin18_oe_n(pin18_oe_n),
    .pin19_in(pin19_in), .pin20_out(pin20_out), .pin21_in(pin21_in), .reset_n_pin(reset_n_pin),
    .external_wake_input(external_wake_input), .iface_sel_pin(iface_sel_pin), .vbus_present(vbus_present),
    .full_speed_plus_pullup(full_speed_plus_pullup), .sys_reset_req(sys_reset_req), .wake_level(wake_level),
    .wake_pulse(wake_pulse), .spi_mode(spi_mode), .data_pending(data_pending), .cfg_load(cfg_load),
    .cfg_in(cfg_in), .msg_in(msg_in), .msg_ready(msg_ready), .utx_in(utx_in), .utx_ready(utx_ready),
    .urx_out(urx_out));
  hcp_host_model hcp_host_model_inst (.sda(sda), .scl(scl), .sda_drv(sda_drv), .rd_evt(rd_evt), .rd_data(rd_data));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask : chk
  task automatic flag(input string name, input logic exp, input logic seen);
    chk(name, {7'h00, exp}, {7'h00, seen});
  endtask : flag
  task automatic check_pop(input string name, input logic [7:0] seen);
    if (byte_q.size() == 0) begin
      $display("mismatch %s expected none seen %h", name, seen);
      miscompares++;
    end else chk(name, byte_q.pop_front(), seen);
  endtask : check_pop
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic drain(input int lim);
    for (n = 0; n < lim && byte_q.size() > 0; n++) @(posedge clk);
    if (byte_q.size() > 0) begin
      $display("mismatch drain expected 0 seen %0d", byte_q.size());
      miscompares++;
      finish_test();
    end
  endtask : drain

  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  task automatic do_reset(input logic sel);
    @(posedge clk);
    iface_sel_pin <= sel;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tick(12);
  endtask : do_reset
  task automatic set_cfg(input hcp_port_cfg_t c);
    @(posedge clk);
    cfg_in <= c;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    tick(3);
  endtask : set_cfg
  task automatic push(input logic [7:0] d);
    @(posedge clk);
    msg_in <= '{1'b1, d};
    @(posedge clk);
    msg_in <= '{1'b0, 8'h00};
    tick(3);
  endtask : push
  task automatic i2c_read(input logic [7:0] reg_a, input int cnt);
    logic [7:0] b;
    hcp_host_model_inst.start_cond();
    hcp_host_model_inst.wr_byte({SLAVE_ADDR_DEFAULT, 1'b0}, ack_n);
    flag("addr_ack", 1'b0, ack_n);
    hcp_host_model_inst.wr_byte(reg_a, ack_n);
    flag("reg_ack", 1'b0, ack_n);
    hcp_host_model_inst.stop_cond();
    hcp_host_model_inst.start_cond();
    hcp_host_model_inst.wr_byte({SLAVE_ADDR_DEFAULT, 1'b1}, ack_n);
    flag("read_ack", 1'b0, ack_n);
    for (int i = 0; i < cnt; i++) hcp_host_model_inst.rd_byte(i == cnt - 1, b);
    hcp_host_model_inst.stop_cond();
  endtask : i2c_read

  always @(posedge clk) if (urx_out.valid === 1'b1) check_pop("uart_rx", urx_out.data);
  always @(posedge rd_evt) check_pop("i2c_rd", rd_data);

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    reset_n_pin = 1'b1;
    external_wake_input = 1'b0;
    iface_sel_pin = 1'b1;
    vbus_present = 1'b0;
    cfg_load = 1'b0;
    cfg_in = PORT_CFG_RST;
    msg_in = '0;
    utx_in = '0;
    loop_en = 1'b0;
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    void'($urandom(37672));
    foreach (vals[i]) vals[i] = 8'($urandom);
    do_reset(1'b1);
    flag("txd_idle", 1'b1, pin20_out);
    flag("sda_released", 1'b1, pin18_oe_n);
    flag("sda_low_level", 1'b0, pin18_out);
    flag("buf_ready", 1'b1, msg_ready);
    flag("uart_ready", 1'b1, utx_ready);
    flag("pending_off", 1'b0, data_pending);
    flag("spi_off", 1'b0, spi_mode);
    @(posedge clk);
    reset_n_pin <= 1'b0;
    vbus_present <= 1'b1;
    tick(6);
    flag("reset_req", 1'b1, sys_reset_req);
    flag("usb_pullup", 1'b1, full_speed_plus_pullup);
    @(posedge clk);
    reset_n_pin <= 1'b1;
    external_wake_input <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1 n += int'(wake_pulse);
    end
    chk("wake_pulses", 8'h01, 8'(n));
    flag("wake_level", 1'b1, wake_level);
    flag("reset_released", 1'b0, sys_reset_req);
    // Short bit time keeps the loopback frames quick
    set_cfg('{1'b1, 1'b0, 1'b0, 8'h03, 16'h0007});
    flag("pending_idle_high", 1'b1, data_pending);
    @(posedge clk);
    loop_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      for (n = 0; n < 200 && utx_ready !== 1'b1; n++) tick(1);
      if (utx_ready !== 1'b1) begin
        $display("mismatch utx_ready expected 1 seen %b", utx_ready);
        miscompares++;
        finish_test();
      end
      @(posedge clk);
      utx_in <= '{1'b1, vals[i]};
      byte_q.push_back(vals[i]);
      @(posedge clk);
      utx_in <= '0;
      drain(300);
    end
    @(posedge clk);
    loop_en <= 1'b0;
    push(vals[0]);
    push(vals[1]);
    flag("pending_below", 1'b1, data_pending);
    push(vals[2]);
    flag("pending_at", 1'b0, data_pending);
    hcp_host_model_inst.start_cond();
    hcp_host_model_inst.wr_byte({7'h55, 1'b0}, ack_n);
    flag("bad_addr_nack", 1'b1, ack_n);
    hcp_host_model_inst.stop_cond();
    // One below the stream register, so the counter must step onto it and stick
    byte_q = {8'h00, vals[0], vals[1], vals[2], FILLER_BYTE};
    i2c_read(8'hFE, 5);
    drain(10);
    tick(3);
    flag("pending_clear", 1'b1, data_pending);
    set_cfg('{1'b1, 1'b1, 1'b1, 8'h01, 16'h0007});
    flag("txd_pending_off", 1'b0, pin20_out);
    push(vals[1]);
    flag("txd_pending_on", 1'b1, pin20_out);
    do_reset(1'b0);
    flag("spi_on", 1'b1, spi_mode);
    push(vals[2]);
    byte_q.push_back(vals[2]);
    @(posedge clk);
    spi_cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      spi_sck <= 1'b1;
      repeat (4) @(posedge clk);
      got[i] = pin20_out;
      spi_sck <= 1'b0;
      repeat (4) @(posedge clk);
    end
    spi_cs_n <= 1'b1;
    check_pop("spi_miso", got);
    flag("spi_sda_idle", 1'b1, pin18_oe_n);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
